// ==== logic/dsw_pkg.sv ====
package dsw_pkg;
    localparam int SPEED_W = 32;
    localparam int DELAY_W = 16;
    localparam int STEADY_W = 16;
    // Status word bit positions
    localparam int BIT_RDY_ON    = 0;
    localparam int BIT_RDY_OP    = 1;
    localparam int BIT_OP_EN     = 2;
    localparam int BIT_FAULT     = 3;
    localparam int BIT_NO_COAST  = 4;
    localparam int BIT_NO_QSTOP  = 5;
    localparam int BIT_INHIBIT   = 6;
    localparam int BIT_WARN      = 7;
    localparam int BIT_TOL       = 8;
    localparam int BIT_PLC       = 9;
    localparam int BIT_REACHED   = 10;
    localparam int BIT_HOME      = 11;
    localparam int BIT_TASK_ACK  = 12;
    localparam int BIT_STOPPED   = 13;
    localparam int CTRL_PLC_BIT  = 10;
    localparam logic [15:0] STATUS_RESET   = 16'h0000;
    // State decoding masks and values
    localparam logic [15:0] STATE_MASK     = 16'h0047;
    localparam logic [15:0] STATE_INHIBIT  = 16'h0040;
    localparam logic [15:0] STATE_AWAIT    = 16'h0001;
    localparam logic [15:0] STATE_PWR_ON   = 16'h0003;
    localparam logic [15:0] RUN_MASK       = 16'h0277;
    localparam logic [15:0] RUN_VALUE      = 16'h0207;

    typedef enum logic [2:0] {
        DSW_INHIBIT = 3'h0,
        DSW_READY   = 3'h1,
        DSW_SW_ON   = 3'h2,
        DSW_OPER    = 3'h3,
        DSW_FAULT   = 3'h4
    } dsw_state_type;

    typedef struct packed {
        logic signed [SPEED_W-1:0] actual;
        logic signed [SPEED_W-1:0] compare;
        logic signed [SPEED_W-1:0] window;
        logic signed [SPEED_W-1:0] threshold;
        logic signed [SPEED_W-1:0] zero_tol;
    } dsw_speed_type;

    typedef struct packed {
        logic fault;
        logic warning;
        logic limit_block;
        logic following_error;
        logic pos_done;
        logic in_target;
        logic homing_ok;
        logic pos_invalid;
        logic abs_encoder;
        logic pos_active;
        logic task_ack;
    } dsw_flags_type;

    typedef struct packed {
        logic inhibit;
        logic awaiting;
        logic power_on;
        logic running;
    } dsw_decode_type;
endpackage

// ==== logic/dsw_speed_window.sv ====
`timescale 1ns/1ns
module dsw_speed_window (
    input  wire logic                           clk_i,
    input  wire logic                           rst_b_i,
    input  wire dsw_pkg::dsw_speed_type         speed_i,
    input  wire logic [dsw_pkg::DELAY_W-1:0]    delay_i,
    output logic                                in_window_o,
    output logic                                tol_ok_o
);
    logic [dsw_pkg::DELAY_W-1:0] cnt;
    logic [dsw_pkg::DELAY_W-1:0] next_cnt;
    logic                        tol;
    logic                        next_tol;
    logic signed [dsw_pkg::SPEED_W:0] lo;
    logic signed [dsw_pkg::SPEED_W:0] hi;

    always_comb begin
        lo = {speed_i.compare[dsw_pkg::SPEED_W-1], speed_i.compare}
           - {speed_i.window[dsw_pkg::SPEED_W-1], speed_i.window};
        hi = {speed_i.compare[dsw_pkg::SPEED_W-1], speed_i.compare}
           + {speed_i.window[dsw_pkg::SPEED_W-1], speed_i.window};
        // Signed comparison against widened bounds
        in_window_o = ($signed({speed_i.actual[dsw_pkg::SPEED_W-1], speed_i.actual}) >= lo)
                   && ($signed({speed_i.actual[dsw_pkg::SPEED_W-1], speed_i.actual}) <= hi); // R1 R19
        next_cnt = cnt;
        next_tol = tol;
        if (!in_window_o) begin
            next_cnt = '0; // R2
            next_tol = 1'b0; // R2
        end else if (cnt >= delay_i) begin
            next_tol = 1'b1; // R2
        end else begin
            next_cnt = cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt <= '0;
            tol <= 1'b0;
        end else begin
            cnt <= next_cnt;
            tol <= next_tol;
        end
    end

    assign tol_ok_o = tol;

    property p_exit_clears;
        @(posedge clk_i) disable iff (!rst_b_i) !in_window_o |=> !tol_ok_o;
    endproperty
    a_exit_clears: assert property (p_exit_clears) else $error("window exit kept flag"); // R2
    property p_set_needs_window;
        @(posedge clk_i) disable iff (!rst_b_i) $rose(tol_ok_o) |-> $past(in_window_o);
    endproperty
    a_set_needs_window: assert property (p_set_needs_window) else $error("flag set outside"); // R2
    c_tol_set: cover property (@(posedge clk_i) disable iff (!rst_b_i) $rose(tol_ok_o));
endmodule

// ==== logic/dsw_state_decode.sv ====
`timescale 1ns/1ns
module dsw_state_decode (
    input  wire logic [15:0]             word_i,
    output dsw_pkg::dsw_decode_type      dec_o
);
    always_comb begin
        dec_o.inhibit  = (word_i & dsw_pkg::STATE_MASK) == dsw_pkg::STATE_INHIBIT; // R15
        dec_o.awaiting = (word_i & dsw_pkg::STATE_MASK) == dsw_pkg::STATE_AWAIT; // R15
        dec_o.power_on = (word_i & dsw_pkg::STATE_MASK) == dsw_pkg::STATE_PWR_ON; // R15
        dec_o.running  = (word_i & dsw_pkg::RUN_MASK) == dsw_pkg::RUN_VALUE; // R20
    end
endmodule

// ==== logic/dsw_status_word.sv ====
`timescale 1ns/1ns
// Behaviour
// R1 - Window flag when speed within compare plus-minus window
// R2 - Bit 8 after full delay; exit restarts
// R3 - Speed mode bit 10 at threshold reached
// R4 - Bit 2 operation enabled; bits 0,1 ready
// R5 - Bit 3 set while any fault
// R6 - Bit 4 low during coast stop request
// R7 - Bit 5 low during quick stop request
// R8 - Bit 7 warning or limit switch block
// R9 - Positioning bit 8 low on following error
// R10 - Bit 9 mirrors control word bit 10
// R11 - Positioning bit 10 done and in target
// R12 - Bit 11 homing valid unless invalidated
// R13 - Bit 13 stopped near zero, no motion
// R14 - Absolute encoder makes home valid directly
// R15 - State decoding by mask 0047h values
// R16 - Master ignores bits 4 and 5; the run decode under mask 0277h still tests them
// R17 - Mode bits follow selected operating mode
// R18 - Read-only 16-bit status word
// R19 - Speed comparisons are signed
// R20 - Run state 0207h under mask 0277h
// R21 - Bits 14 and 15 read zero
module dsw_status_word (
    input  wire logic                           clk_i,
    input  wire logic                           rst_b_i,
    input  wire dsw_pkg::dsw_state_type         state_i,
    input  wire dsw_pkg::dsw_flags_type         flags_i,
    input  wire dsw_pkg::dsw_speed_type         speed_i,
    input  wire logic [dsw_pkg::DELAY_W-1:0]    delay_i,
    input  wire logic [15:0]                    control_word_i,
    input  wire logic                           positioning_mode_i,
    output logic [15:0]                         status_word_o,
    output dsw_pkg::dsw_decode_type             decode_o,
    output logic                                homing_position_valid_o
);
    logic        in_window;
    logic        tol_ok;
    logic [15:0] word;
    logic [15:0] next_word;
    logic        home;
    logic        next_home;
    logic        coast_stop_request;
    logic        quick_stop_request;
    logic        at_zero;

    dsw_speed_window u_window (
        .clk_i       (clk_i),
        .rst_b_i     (rst_b_i),
        .speed_i     (speed_i),
        .delay_i     (delay_i),
        .in_window_o (in_window),
        .tol_ok_o    (tol_ok)
    );

    dsw_state_decode u_decode (
        .word_i (word),
        .dec_o  (decode_o)
    );

    function automatic logic within_tol(input logic signed [dsw_pkg::SPEED_W-1:0] v,
                                        input logic signed [dsw_pkg::SPEED_W-1:0] t);
        within_tol = (v <= t) && (v >= -t);
    endfunction

    always_comb begin
        coast_stop_request = !control_word_i[1]; // R6
        quick_stop_request = control_word_i[1] && !control_word_i[2]; // R7
        at_zero = within_tol(speed_i.actual, speed_i.zero_tol);
        // Home valid latch
        next_home = home;
        if (flags_i.pos_invalid) begin
            next_home = 1'b0; // R12
        end else if (flags_i.homing_ok || flags_i.abs_encoder) begin
            next_home = 1'b1; // R12 R14
        end
        next_word = dsw_pkg::STATUS_RESET; // R21
        next_word[dsw_pkg::BIT_RDY_ON] = (state_i == dsw_pkg::DSW_READY)
                                      || (state_i == dsw_pkg::DSW_SW_ON)
                                      || (state_i == dsw_pkg::DSW_OPER); // R4
        next_word[dsw_pkg::BIT_RDY_OP] = (state_i == dsw_pkg::DSW_SW_ON)
                                      || (state_i == dsw_pkg::DSW_OPER); // R4
        next_word[dsw_pkg::BIT_OP_EN] = (state_i == dsw_pkg::DSW_OPER); // R4
        next_word[dsw_pkg::BIT_FAULT] = flags_i.fault; // R5
        next_word[dsw_pkg::BIT_NO_COAST] = !coast_stop_request; // R6
        next_word[dsw_pkg::BIT_NO_QSTOP] = !quick_stop_request; // R7
        next_word[dsw_pkg::BIT_INHIBIT] = (state_i == dsw_pkg::DSW_INHIBIT)
                                       || (state_i == dsw_pkg::DSW_FAULT); // R15
        next_word[dsw_pkg::BIT_WARN] = flags_i.warning || flags_i.limit_block; // R8
        next_word[dsw_pkg::BIT_PLC] = control_word_i[dsw_pkg::CTRL_PLC_BIT]; // R10
        if (positioning_mode_i) begin // R17
            next_word[dsw_pkg::BIT_TOL] = !flags_i.following_error; // R9
            next_word[dsw_pkg::BIT_REACHED] = flags_i.pos_done && flags_i.in_target; // R11
            next_word[dsw_pkg::BIT_HOME] = next_home; // R12
            next_word[dsw_pkg::BIT_TASK_ACK] = flags_i.task_ack;
            next_word[dsw_pkg::BIT_STOPPED] = at_zero && !flags_i.pos_active
                                           && !quick_stop_request; // R13
        end else begin
            next_word[dsw_pkg::BIT_TOL] = tol_ok; // R2
            next_word[dsw_pkg::BIT_REACHED] = speed_i.actual >= speed_i.threshold; // R3 R19
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            word <= dsw_pkg::STATUS_RESET;
            home <= 1'b0;
        end else begin
            word <= next_word;
            home <= next_home;
        end
    end

    // No write path exists: the word is output only
    assign status_word_o = word; // R18
    assign homing_position_valid_o = home;

    property p_fault;
        @(posedge clk_i) disable iff (!rst_b_i) flags_i.fault |=> status_word_o[3];
    endproperty
    a_fault: assert property (p_fault) else $error("fault bit missing"); // R5
    property p_coast;
        @(posedge clk_i) disable iff (!rst_b_i) !control_word_i[1] |=> !status_word_o[4];
    endproperty
    a_coast: assert property (p_coast) else $error("coast stop bit wrong"); // R6
    property p_qstop;
        @(posedge clk_i) disable iff (!rst_b_i)
            (control_word_i[2:1] == 2'b01) |=> !status_word_o[5];
    endproperty
    a_qstop: assert property (p_qstop) else $error("quick stop bit wrong"); // R7
    property p_warn;
        @(posedge clk_i) disable iff (!rst_b_i)
            (flags_i.warning || flags_i.limit_block) |=> status_word_o[7];
    endproperty
    a_warn: assert property (p_warn) else $error("warning bit missing"); // R8
    property p_plc;
        @(posedge clk_i) disable iff (!rst_b_i) 1'b1 |=> status_word_o[9] == $past(control_word_i[10]);
    endproperty
    a_plc: assert property (p_plc) else $error("plc bit not mirrored"); // R10
    property p_free;
        @(posedge clk_i) disable iff (!rst_b_i) status_word_o[15:14] == 2'b00;
    endproperty
    a_free: assert property (p_free) else $error("free bits nonzero"); // R21
    property p_oper;
        @(posedge clk_i) disable iff (!rst_b_i)
            state_i == dsw_pkg::DSW_OPER |=> status_word_o[2] && decode_o.power_on == 1'b0;
    endproperty
    a_oper: assert property (p_oper) else $error("operation decode wrong"); // R4
    property p_abs;
        @(posedge clk_i) disable iff (!rst_b_i)
            flags_i.abs_encoder && !flags_i.pos_invalid |=> homing_position_valid_o;
    endproperty
    a_abs: assert property (p_abs) else $error("abs encoder home invalid"); // R14
    property p_reached;
        @(posedge clk_i) disable iff (!rst_b_i)
            positioning_mode_i && !(flags_i.pos_done && flags_i.in_target) |=> !status_word_o[10];
    endproperty
    a_reached: assert property (p_reached) else $error("target bit wrong"); // R11

    // Clearing side of the plain status bits
    property p_fault_clear;
        @(posedge clk_i) disable iff (!rst_b_i)
            !flags_i.fault |=> !status_word_o[3];
    endproperty
    a_fault_clear: assert property (p_fault_clear) else $error("fault bit stuck"); // R5
    property p_warn_clear;
        @(posedge clk_i) disable iff (!rst_b_i)
            !flags_i.warning && !flags_i.limit_block |=> !status_word_o[7];
    endproperty
    a_warn_clear: assert property (p_warn_clear) else $error("warning bit stuck"); // R8
    property p_coast_clear;
        @(posedge clk_i) disable iff (!rst_b_i)
            control_word_i[1] |=> status_word_o[4];
    endproperty
    a_coast_clear: assert property (p_coast_clear) else $error("coast bit stuck low"); // R6
    property p_qstop_clear;
        @(posedge clk_i) disable iff (!rst_b_i)
            (control_word_i[2:1] != 2'b01) |=> status_word_o[5];
    endproperty
    a_qstop_clear: assert property (p_qstop_clear) else $error("quick stop bit stuck"); // R7

    // State bits and the state decode
    property p_rdy_on;
        @(posedge clk_i) disable iff (!rst_b_i)
            state_i inside {dsw_pkg::DSW_READY, dsw_pkg::DSW_SW_ON, dsw_pkg::DSW_OPER}
            |=> status_word_o[0];
    endproperty
    a_rdy_on: assert property (p_rdy_on) else $error("ready bit missing"); // R4
    property p_rdy_op;
        @(posedge clk_i) disable iff (!rst_b_i)
            state_i inside {dsw_pkg::DSW_SW_ON, dsw_pkg::DSW_OPER} |=> status_word_o[1];
    endproperty
    a_rdy_op: assert property (p_rdy_op) else $error("operate bit missing"); // R4
    property p_op_off;
        @(posedge clk_i) disable iff (!rst_b_i)
            state_i != dsw_pkg::DSW_OPER |=> !status_word_o[2];
    endproperty
    a_op_off: assert property (p_op_off) else $error("enabled bit stuck"); // R4
    property p_not_rdy;
        @(posedge clk_i) disable iff (!rst_b_i)
            state_i inside {dsw_pkg::DSW_INHIBIT, dsw_pkg::DSW_FAULT}
            |=> status_word_o[2:0] == 3'b000;
    endproperty
    a_not_rdy: assert property (p_not_rdy) else $error("ready bits while inhibited"); // R4
    property p_inhibit_set;
        @(posedge clk_i) disable iff (!rst_b_i)
            state_i inside {dsw_pkg::DSW_INHIBIT, dsw_pkg::DSW_FAULT} |=> status_word_o[6];
    endproperty
    a_inhibit_set: assert property (p_inhibit_set) else $error("inhibit bit missing"); // R15
    property p_inhibit_clear;
        @(posedge clk_i) disable iff (!rst_b_i)
            state_i inside {dsw_pkg::DSW_READY, dsw_pkg::DSW_SW_ON, dsw_pkg::DSW_OPER}
            |=> !status_word_o[6];
    endproperty
    a_inhibit_clear: assert property (p_inhibit_clear) else $error("inhibit bit stuck"); // R15
    property p_dec_inhibit;
        @(posedge clk_i) disable iff (!rst_b_i)
            state_i inside {dsw_pkg::DSW_INHIBIT, dsw_pkg::DSW_FAULT} |=> decode_o.inhibit;
    endproperty
    a_dec_inhibit: assert property (p_dec_inhibit) else $error("inhibit decode wrong"); // R15
    property p_dec_await;
        @(posedge clk_i) disable iff (!rst_b_i)
            state_i == dsw_pkg::DSW_READY |=> decode_o.awaiting;
    endproperty
    a_dec_await: assert property (p_dec_await) else $error("awaiting decode wrong"); // R15
    property p_dec_pwr;
        @(posedge clk_i) disable iff (!rst_b_i)
            state_i == dsw_pkg::DSW_SW_ON |=> decode_o.power_on;
    endproperty
    a_dec_pwr: assert property (p_dec_pwr) else $error("power on decode wrong"); // R15

    // Mode dependent bits
    property p_tol_err;
        @(posedge clk_i) disable iff (!rst_b_i)
            positioning_mode_i && flags_i.following_error |=> !status_word_o[8];
    endproperty
    a_tol_err: assert property (p_tol_err) else $error("following error not shown"); // R9
    property p_tol_free;
        @(posedge clk_i) disable iff (!rst_b_i)
            positioning_mode_i && !flags_i.following_error |=> status_word_o[8];
    endproperty
    a_tol_free: assert property (p_tol_free) else $error("tolerance bit stuck low"); // R9
    property p_tol_spd;
        @(posedge clk_i) disable iff (!rst_b_i)
            !positioning_mode_i |=> status_word_o[8] == $past(tol_ok);
    endproperty
    a_tol_spd: assert property (p_tol_spd) else $error("speed window bit wrong"); // R2 R17
    property p_reached_set;
        @(posedge clk_i) disable iff (!rst_b_i)
            positioning_mode_i && flags_i.pos_done && flags_i.in_target |=> status_word_o[10];
    endproperty
    a_reached_set: assert property (p_reached_set) else $error("target bit missing"); // R11
    property p_thr_set;
        @(posedge clk_i) disable iff (!rst_b_i)
            !positioning_mode_i && (speed_i.actual >= speed_i.threshold) |=> status_word_o[10];
    endproperty
    a_thr_set: assert property (p_thr_set) else $error("threshold bit missing"); // R3 R19
    property p_thr_clear;
        @(posedge clk_i) disable iff (!rst_b_i)
            !positioning_mode_i && (speed_i.actual < speed_i.threshold) |=> !status_word_o[10];
    endproperty
    a_thr_clear: assert property (p_thr_clear) else $error("threshold bit stuck"); // R3 R19
    property p_spd_free;
        @(posedge clk_i) disable iff (!rst_b_i)
            !positioning_mode_i |=> status_word_o[13:11] == 3'b000;
    endproperty
    a_spd_free: assert property (p_spd_free) else $error("speed mode free bits set"); // R17

    // Home valid latch
    property p_home_clear;
        @(posedge clk_i) disable iff (!rst_b_i)
            flags_i.pos_invalid |=> !homing_position_valid_o;
    endproperty
    a_home_clear: assert property (p_home_clear) else $error("home kept after error"); // R12
    property p_home_set;
        @(posedge clk_i) disable iff (!rst_b_i)
            flags_i.homing_ok && !flags_i.pos_invalid |=> homing_position_valid_o;
    endproperty
    a_home_set: assert property (p_home_set) else $error("home not set"); // R12
    property p_home_hold;
        @(posedge clk_i) disable iff (!rst_b_i)
            !flags_i.homing_ok && !flags_i.abs_encoder && !flags_i.pos_invalid
            |=> $stable(homing_position_valid_o);
    endproperty
    a_home_hold: assert property (p_home_hold) else $error("home changed unprompted"); // R12
    property p_home_bit;
        @(posedge clk_i) disable iff (!rst_b_i)
            positioning_mode_i |=> status_word_o[11] == homing_position_valid_o;
    endproperty
    a_home_bit: assert property (p_home_bit) else $error("home bit differs"); // R12 R17

    // Standstill bit
    property p_stop_set;
        @(posedge clk_i) disable iff (!rst_b_i)
            positioning_mode_i && !flags_i.pos_active && (control_word_i[2:1] != 2'b01)
            && (speed_i.actual <= speed_i.zero_tol) && (speed_i.actual >= -speed_i.zero_tol)
            |=> status_word_o[13];
    endproperty
    a_stop_set: assert property (p_stop_set) else $error("stopped bit missing"); // R13
    property p_stop_motion;
        @(posedge clk_i) disable iff (!rst_b_i)
            positioning_mode_i && flags_i.pos_active |=> !status_word_o[13];
    endproperty
    a_stop_motion: assert property (p_stop_motion) else $error("stopped while moving"); // R13
    property p_stop_qs;
        @(posedge clk_i) disable iff (!rst_b_i)
            positioning_mode_i && (control_word_i[2:1] == 2'b01) |=> !status_word_o[13];
    endproperty
    a_stop_qs: assert property (p_stop_qs) else $error("stopped during quick stop"); // R13
    property p_stop_speed;
        @(posedge clk_i) disable iff (!rst_b_i)
            positioning_mode_i && (speed_i.actual > speed_i.zero_tol) |=> !status_word_o[13];
    endproperty
    a_stop_speed: assert property (p_stop_speed) else $error("stopped above band"); // R13

    c_run: cover property (@(posedge clk_i) disable iff (!rst_b_i) decode_o.running);
    c_home: cover property (@(posedge clk_i) disable iff (!rst_b_i) homing_position_valid_o);
    c_inhibit: cover property (@(posedge clk_i) disable iff (!rst_b_i) decode_o.inhibit);
    c_stopped: cover property (@(posedge clk_i) disable iff (!rst_b_i) status_word_o[13]);
endmodule

// ==== tb/dsw_plc_model.sv ====
`timescale 1ns/1ns
module dsw_plc_model (
    input  wire logic [15:0]        status_word_i,
    output dsw_pkg::dsw_decode_type dec_o
);
    logic [15:0] st;
    logic [15:0] rn;
    // Master state decode; bits 4 and 5 stay outside the state mask
    always_comb begin
        st = status_word_i & dsw_pkg::STATE_MASK;
        rn = status_word_i & dsw_pkg::RUN_MASK;
        dec_o.inhibit = st == dsw_pkg::STATE_INHIBIT;
        dec_o.awaiting = st == dsw_pkg::STATE_AWAIT;
        dec_o.power_on = st == dsw_pkg::STATE_PWR_ON;
        dec_o.running = rn == dsw_pkg::RUN_VALUE;
    end
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/1ns
module tb;
    logic                          clk_i;
    logic                          rst_b_i;
    dsw_pkg::dsw_state_type        state;
    dsw_pkg::dsw_flags_type        flags;
    dsw_pkg::dsw_speed_type        speed;
    logic [dsw_pkg::DELAY_W-1:0]   delay;
    logic [15:0]                   cw;
    logic                          pmode;
    logic [15:0]                   word;
    dsw_pkg::dsw_decode_type       dec;
    dsw_pkg::dsw_decode_type       mdec;
    logic                          hpv;
    int                            fails;
    int                            total_checks;

    dsw_status_word i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .state_i(state),
        .flags_i(flags), .speed_i(speed), .delay_i(delay), .control_word_i(cw),
        .positioning_mode_i(pmode), .status_word_o(word), .decode_o(dec),
        .homing_position_valid_o(hpv));
    dsw_plc_model i_plc (.status_word_i(word), .dec_o(mdec));

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    task automatic wt(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic spd(input int a, input int c, input int w, input int t, input int z);
        speed <= '{a, c, w, t, z};
    endtask

    task automatic t_state;
        logic [15:0] e [5];
        e = '{16'h0040, 16'h0001, 16'h0003, 16'h0007, 16'h0040};
        for (int s = 0; s < 5; s++) begin
            @(posedge clk_i);
            state <= dsw_pkg::dsw_state_type'(3'(s));
            wt(2);
            chk("state bits", word & dsw_pkg::STATE_MASK, e[s]);
            chk("decode", {12'h000, dec}, {12'h000, mdec});
        end
    endtask

    task automatic t_ctrl;
        logic [15:0] c [3];
        logic [15:0] e [3];
        c = '{16'h0406, 16'h0004, 16'h0402};
        e = '{16'h2230, 16'h2020, 16'h0210};
        for (int i = 0; i < 3; i++) begin
            @(posedge clk_i);
            cw <= c[i];
            wt(2);
            chk("command bits", word & 16'he230, e[i]);
        end
        @(posedge clk_i);
        cw <= 16'h0406;
    endtask

    task automatic t_flags;
        logic [10:0] f [14];
        logic [15:0] m [14];
        logic [15:0] e [14];
        f = '{11'h400, 11'h200, 11'h100, 11'h080, 11'h000, 11'h040, 11'h060,
              11'h010, 11'h000, 11'h008, 11'h004, 11'h018, 11'h002, 11'h001};
        m = '{16'h0088, 16'h0088, 16'h0088, 16'h0100, 16'h0100, 16'h0400, 16'h0400,
              16'h0800, 16'h0800, 16'h0800, 16'h0800, 16'h0800, 16'h2000, 16'h1000};
        e = '{16'h0008, 16'h0080, 16'h0080, 16'h0000, 16'h0100, 16'h0000, 16'h0400,
              16'h0800, 16'h0800, 16'h0000, 16'h0800, 16'h0000, 16'h0000, 16'h1000};
        for (int i = 0; i < 14; i++) begin
            @(posedge clk_i);
            flags <= f[i];
            wt(2);
            chk("flag bits", word & m[i], e[i]);
            if (m[i] == 16'h0800) begin
                chk("home valid", {15'h0000, hpv}, e[i] >> 11);
            end
        end
    endtask

    task automatic t_reset;
        @(posedge clk_i);
        flags <= 11'h010;
        wt(2);
        chk("home before reset", {15'h0000, hpv}, 16'h0001);
        @(posedge clk_i);
        rst_b_i <= 1'b0;
        flags <= '0;
        wt(1);
        chk("mid reset word", word, dsw_pkg::STATUS_RESET);
        chk("mid reset home", {15'h0000, hpv}, 16'h0000);
        @(posedge clk_i);
        rst_b_i <= 1'b1;
        wt(2);
        chk("after reset", word & 16'h0a30, 16'h0230);
    endtask

    task automatic t_speed;
        int n;
        @(posedge clk_i);
        flags <= '0;
        spd(3, -100, 10, 3, 2);
        wt(2);
        chk("outside zero band", word & 16'h2000, 16'h0000);
        @(posedge clk_i);
        spd(-2, -100, 10, 3, 2);
        wt(2);
        chk("inside zero band", word & 16'h2000, 16'h2000);
        @(posedge clk_i);
        pmode <= 1'b0;
        delay <= 16'h0004;
        spd(-120, -100, 10, 3, 2);
        wt(3);
        chk("outside window", word & 16'h3d00, 16'h0000);
        @(posedge clk_i);
        spd(-110, -100, 10, 3, 2);
        for (n = 0; n < 40; n++) begin
            wt(1);
            if (word[dsw_pkg::BIT_TOL] === 1'b1) break;
        end
        if (n == 40) begin
            fails++;
        end
        chk("delay span", {15'h0000, n >= 4 && n <= 8}, 16'h0001);
        @(posedge clk_i);
        spd(-89, -100, 10, 3, 2);
        @(posedge clk_i);
        spd(-90, -100, 10, 3, 2);
        wt(3);
        chk("restarted delay", word & 16'h0100, 16'h0000);
        @(posedge clk_i);
        spd(3, -100, 10, 3, 2);
        wt(2);
        chk("threshold met", word & 16'h3c00, 16'h0400);
        @(posedge clk_i);
        spd(2, -100, 10, 3, 2);
        wt(2);
        chk("below threshold", word & 16'h0400, 16'h0000);
    endtask

    initial begin
        fails = 0;
        total_checks = 0;
        rst_b_i = 1'b0;
        state = dsw_pkg::DSW_INHIBIT;
        flags = '0;
        speed = '0;
        speed.zero_tol = 32'sd2;
        delay = 16'h0004;
        cw = 16'h0406;
        pmode = 1'b1;
        repeat (10) @(posedge clk_i);
        #1;
        chk("reset word", word, dsw_pkg::STATUS_RESET);
        chk("reset home", {15'h0000, hpv}, 16'h0000);
        @(posedge clk_i);
        rst_b_i <= 1'b1;
        t_state();
        t_ctrl();
        t_flags();
        t_reset();
        t_speed();
        finish_test();
    end
endmodule
